// ===== design/branch_unit_map.vh
`ifndef BRANCH_UNIT_MAP_VH
`define BRANCH_UNIT_MAP_VH
// ----------------------------------------
// Branch operation codes
// ----------------------------------------
`define OP_NONE 4'h0
`define OP_CARRY_SET 4'h1
`define OP_BELOW 4'h2
`define OP_CARRY_CLEAR 4'h3
`define OP_NOT_BELOW 4'h4
`define OP_ZERO 4'h5
`define OP_EQUAL 4'h6
`define OP_NONZERO 4'h7
`define OP_UNEQUAL 4'h8
`define OP_BIT_SET 4'h9
`define OP_BIT_CLEAR 4'ha
`define OP_BIT_TEST_CLR 4'hb
`define OP_LOOP 4'hc
// ----------------------------------------
// Bit operand kinds
// ----------------------------------------
`define SRC_SADDR 3'h0
`define SRC_SFR 3'h1
`define SRC_ACC 3'h2
`define SRC_X 3'h3
`define SRC_PSW 3'h4
// ----------------------------------------
// Loop destination kinds
// ----------------------------------------
`define LOOP_REG 1'h0
`define LOOP_SADDR 1'h1
// ----------------------------------------
// Instruction lengths
// ----------------------------------------
`define LEN_FLAG_BR 3'h2
`define LEN_THREE 3'h3
`define LEN_FOUR 3'h4
`define LEN_LOOP_REG 3'h2
`define LEN_LOOP_SADDR 3'h3
// ----------------------------------------
// Status word flag positions
// ----------------------------------------
`define PSW_CY 0
`define PSW_AC 4
`define PSW_Z 6
`endif

// ===== design/branch_condition.v
`timescale 1ns/100ps
`default_nettype none
`include "branch_unit_map.vh"
module branch_condition (
   input wire [3:0] op,
   input wire [2:0] bit_src,
   input wire carry_flag,
   input wire zero_flag,
   input wire bit_value,
   input wire [7:0] loop_result,
   input wire loop_dst,
   output reg taken,
   output reg [2:0] length,
   output reg clear_bit
);
   // ----------------------------------------
   // Condition and length decode
   // ----------------------------------------
   always @* begin
      taken = 1'b0;
      length = `LEN_FLAG_BR;
      clear_bit = 1'b0;
      case (op)
         `OP_CARRY_SET, `OP_BELOW: begin
            taken = carry_flag;
         end
         `OP_CARRY_CLEAR, `OP_NOT_BELOW: begin
            taken = ~carry_flag;
         end
         `OP_ZERO, `OP_EQUAL: begin
            taken = zero_flag;
         end
         `OP_NONZERO, `OP_UNEQUAL: begin
            taken = ~zero_flag;
         end
         `OP_BIT_SET: begin
            taken = bit_value;
            length = (bit_src == `SRC_SFR) ? `LEN_FOUR : `LEN_THREE;
         end
         `OP_BIT_CLEAR: begin
            taken = ~bit_value;
            length = (bit_src == `SRC_SFR || bit_src == `SRC_SADDR) ? `LEN_FOUR : `LEN_THREE;
         end
         `OP_BIT_TEST_CLR: begin
            taken = bit_value;
            clear_bit = bit_value;
            length = (bit_src == `SRC_SFR || bit_src == `SRC_SADDR) ? `LEN_FOUR : `LEN_THREE;
         end
         `OP_LOOP: begin
            taken = (loop_result != 8'h00);
            length = (loop_dst == `LOOP_SADDR) ? `LEN_LOOP_SADDR : `LEN_LOOP_REG;
         end
         default: begin
            taken = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// ===== design/branch_target.v
`timescale 1ns/100ps
`default_nettype none
module branch_target #(
   parameter ADDR_WIDTH = 20
) (
   input wire [ADDR_WIDTH-1:0] pc,
   input wire [2:0] length,
   input wire [7:0] jump_offset_byte,
   output wire [ADDR_WIDTH-1:0] next_seq,
   output wire [ADDR_WIDTH-1:0] target
);
   // ----------------------------------------
   // Relative target
   // ----------------------------------------
   // Sign extension keeps the reach at -128..+127 from the following address
   wire [ADDR_WIDTH-1:0] disp_ext;
   assign disp_ext = {{(ADDR_WIDTH-8){jump_offset_byte[7]}}, jump_offset_byte};
   assign next_seq = pc + {{(ADDR_WIDTH-3){1'b0}}, length};
   assign target = next_seq + disp_ext;
endmodule
`default_nettype wire

// ===== design/conditional_branch_unit.v
// Functional notes
// - A carry-clear branch jumps to its address plus 2 plus the offset when carry is 0.
// - A zero branch jumps to its address plus 2 plus the offset when zero is 1.
// - A nonzero branch jumps to its address plus 2 plus the offset when zero is 0.
// - Each pair of alias branch names decodes to one identical operation.
// - Bit-set branch jumps on bit 1, length 4 for special-function bits and 3 otherwise.
// - Bit-clear branch jumps on bit 0, length 4 for short-direct and special-function, else 3.
// - Test-and-clear branch clears a set bit and jumps, length 4 or 3 as bit-clear, else does nothing.
// - Test-and-clear on a status-word bit clears only that flag.
// - Loop instruction decrements its register (2 bytes) or memory byte (3 bytes), jumps if nonzero.
// - A false condition has no further effect and execution goes on sequentially.
// - The loop instruction leaves zero, auxiliary carry and carry unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "branch_unit_map.vh"
module conditional_branch_unit #(
   parameter ADDR_WIDTH = 20
) (
   input wire clk,
   input wire reset,
   input wire start,
   input wire [3:0] op,
   input wire [2:0] bit_src,
   input wire [2:0] bit_index,
   input wire [7:0] operand_byte,
   input wire loop_dst,
   input wire [7:0] jump_offset_byte,
   input wire [ADDR_WIDTH-1:0] pc,
   input wire [7:0] program_status_word,
   output reg done,
   output reg [ADDR_WIDTH-1:0] next_pc,
   output reg pc_load_taken,
   output reg operand_write,
   output reg [7:0] operand_result,
   output reg psw_write,
   output reg [7:0] psw_result
);
   // ----------------------------------------
   // Operand evaluation
   // ----------------------------------------
   wire carry_flag;
   wire zero_flag;
   wire [7:0] bit_source;
   wire bit_value;
   wire [7:0] loop_result;
   wire [7:0] bit_mask;
   wire taken;
   wire [2:0] length;
   wire clear_bit;
   wire [ADDR_WIDTH-1:0] next_seq;
   wire [ADDR_WIDTH-1:0] target;

   assign carry_flag = program_status_word[`PSW_CY];
   assign zero_flag = program_status_word[`PSW_Z];
   // Status-word bits are read from the live flags, not from the operand path
   assign bit_source = (bit_src == `SRC_PSW) ? program_status_word : operand_byte;
   assign bit_value = bit_source[bit_index];
   assign bit_mask = 8'h01 << bit_index;
   assign loop_result = operand_byte - 8'h01;

   branch_condition u_cond (
      .op(op),
      .bit_src(bit_src),
      .carry_flag(carry_flag),
      .zero_flag(zero_flag),
      .bit_value(bit_value),
      .loop_result(loop_result),
      .loop_dst(loop_dst),
      .taken(taken),
      .length(length),
      .clear_bit(clear_bit)
   );

   branch_target #(
      .ADDR_WIDTH(ADDR_WIDTH)
   ) u_target (
      .pc(pc),
      .length(length),
      .jump_offset_byte(jump_offset_byte),
      .next_seq(next_seq),
      .target(target)
   );

   // ----------------------------------------
   // Result registers
   // ----------------------------------------
   // One-cycle latency: results are registered so every output is a flop
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         done <= 1'b0;
         next_pc <= {ADDR_WIDTH{1'b0}};
         pc_load_taken <= 1'b0;
         operand_write <= 1'b0;
         operand_result <= 8'h00;
         psw_write <= 1'b0;
         psw_result <= 8'h00;
      end else begin
         done <= start;
         operand_write <= 1'b0;
         psw_write <= 1'b0;
         pc_load_taken <= 1'b0;
         if (start) begin
            next_pc <= taken ? target : next_seq;
            pc_load_taken <= taken;
            psw_result <= program_status_word;
            operand_result <= operand_byte;
            if (op == `OP_LOOP) begin
               // Destination always written, flags never touched
               operand_write <= 1'b1;
               operand_result <= loop_result;
            end else if (clear_bit) begin
               if (bit_src == `SRC_PSW) begin
                  psw_write <= 1'b1;
                  psw_result <= program_status_word & ~bit_mask;
               end else begin
                  operand_write <= 1'b1;
                  operand_result <= operand_byte & ~bit_mask;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== bench/branch_unit_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module branch_unit_monitor #(parameter ADDR_WIDTH = 20) (
   input wire clk,
   input wire reset,
   input wire start,
   input wire [3:0] op,
   input wire [2:0] bit_src,
   input wire [2:0] bit_index,
   input wire [7:0] operand_byte,
   input wire [7:0] jump_offset_byte,
   input wire [ADDR_WIDTH-1:0] pc,
   input wire [7:0] program_status_word,
   input wire done,
   input wire [ADDR_WIDTH-1:0] next_pc,
   input wire pc_load_taken,
   input wire operand_write,
   input wire [7:0] operand_result,
   input wire psw_write,
   input wire [7:0] psw_result
);
   // Targets kept at address width so wrap-around matches the design
   wire [7:0] f = program_status_word;
   wire [ADDR_WIDTH-1:0] n = pc + 2;
   wire [ADDR_WIDTH-1:0] t = n + {{(ADDR_WIDTH-8){jump_offset_byte[7]}}, jump_offset_byte};
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_jmp; done && pc_load_taken && next_pc == $past(t); endsequence
   property p_cs; start && op inside {4'h1, 4'h2} && f[0] |=> s_jmp; endproperty
   a_cs: assert property (p_cs) else $error("carry set");
   property p_cc; start && op inside {4'h3, 4'h4} && !f[0] |=> s_jmp; endproperty
   a_cc: assert property (p_cc) else $error("carry clear");
   property p_z; start && op inside {4'h5, 4'h6} && f[6] |=> s_jmp; endproperty
   a_z: assert property (p_z) else $error("zero");
   property p_nz; start && op inside {4'h7, 4'h8} && !f[6] |=> s_jmp; endproperty
   a_nz: assert property (p_nz) else $error("nonzero");
   property p_no; start && op == 4'h1 && !f[0] |=> done && !pc_load_taken && next_pc == $past(n); endproperty
   a_no: assert property (p_no) else $error("false branch");
   property p_tc; start && op == 4'hb && bit_src == 3'h4 && f[bit_index]
      |=> psw_write && psw_result == ($past(f) & ~(8'h01 << $past(bit_index))); endproperty
   a_tc: assert property (p_tc) else $error("status clear");
   property p_lp; start && op == 4'hc
      |=> operand_write && !psw_write && operand_result == $past(operand_byte) - 8'h01; endproperty
   a_lp: assert property (p_lp) else $error("loop");
   property p_fl; start && op inside {[4'h1:4'ha]} |=> !psw_write && !operand_write; endproperty
   a_fl: assert property (p_fl) else $error("flags kept");
   property p_idle; !start |=> !done && !pc_load_taken && !operand_write && !psw_write; endproperty
   a_idle: assert property (p_idle) else $error("idle pulses");
endmodule
bind conditional_branch_unit branch_unit_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) branch_unit_monitor_inst (.*);
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   reg clk, reset, start, loop_dst, e_tk, e_ow, e_pw, e_v, b;
   reg [3:0] op, m;
   reg [2:0] bit_src, bit_index;
   reg [7:0] operand_byte, jump_offset_byte, program_status_word, e_or, e_ps;
   reg [19:0] pc, e_pc;
   wire done, pc_load_taken, operand_write, psw_write;
   wire [19:0] next_pc;
   wire [7:0] operand_result, psw_result;
   integer seed = 32'h256a, n_fail = 0, cmp_count = 0, i;
   conditional_branch_unit conditional_branch_unit_inst (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("FAIL %0t %h %h", $time, got, exp);
         end
      end
   endtask
   function [3:0] model(input [3:0] o, input [2:0] s, input bv, input [7:0] ob, input ld, input [7:0] f);
      case (o)
         4'h1, 4'h2: model = {f[0], 3'h2};
         4'h3, 4'h4: model = {~f[0], 3'h2};
         4'h5, 4'h6: model = {f[6], 3'h2};
         4'h7, 4'h8: model = {~f[6], 3'h2};
         4'h9: model = {bv, s == 3'h1 ? 3'h4 : 3'h3};
         4'ha: model = {~bv, s < 3'h2 ? 3'h4 : 3'h3};
         4'hb: model = {bv, s < 3'h2 ? 3'h4 : 3'h3};
         4'hc: model = {ob != 8'h01, ld ? 3'h3 : 3'h2};
         default: model = 4'h2;
      endcase
   endfunction
   // Back to back: the next start is driven while the last result is checked
   task step(input s, input [3:0] o, input [2:0] src, input [2:0] idx, input [7:0] ob, input ld, input [7:0] d,
      input [19:0] p, input [7:0] f);
      begin
         {start, op, bit_src, bit_index, operand_byte, loop_dst, jump_offset_byte, pc, program_status_word}
            <= {s, o, src, idx, ob, ld, d, p, f};
         #1;
         chk(done, e_v);
         if (e_v) begin
            chk({pc_load_taken, next_pc, operand_write, psw_write}, {e_tk, e_pc, e_ow, e_pw});
            if (e_ow) chk(operand_result, e_or);
            if (e_pw) chk(psw_result, e_ps);
         end else begin
            chk({pc_load_taken, operand_write, psw_write}, 32'h0);
         end
         b = src == 3'h4 ? f[idx] : ob[idx];
         m = model(o, src, b, ob, ld, f);
         e_v = s;
         e_tk = m[3];
         e_pc = p + m[2:0] + (m[3] ? {{12{d[7]}}, d} : 20'h0);
         e_ow = o == 4'hc || (o == 4'hb && b && src != 3'h4);
         e_pw = o == 4'hb && b && src == 3'h4;
         e_or = o == 4'hc ? ob - 8'h01 : ob & ~(8'h01 << idx);
         e_ps = f & ~(8'h01 << idx);
         @(posedge clk);
      end
   endtask
   task final_report;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      #50000;
      n_fail = n_fail + 1;
      final_report;
   end
   initial begin
      reset = 1'b1;
      e_v = 1'b0;
      {start, op, bit_src, bit_index, operand_byte, loop_dst, jump_offset_byte, pc, program_status_word} = 56'h0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      step(1'b1, 4'hb, 3'h4, 3'h0, 8'h00, 1'b0, 8'h10, 20'h00100, 8'h01);
      step(1'b1, 4'hc, 3'h0, 3'h0, 8'h01, 1'b0, 8'h80, 20'h00040, 8'h51);
      step(1'b1, 4'hc, 3'h0, 3'h0, 8'h00, 1'b1, 8'h7f, 20'hfffff, 8'h00);
      for (i = 0; i < 800; i = i + 1)
         step($random(seed) % 8 != 0, {$random(seed)} % 14, {$random(seed)} % 5, $random(seed), $random(seed),
            $random(seed), $random(seed), $random(seed), $random(seed));
      step(1'b0, 4'h0, 3'h0, 3'h0, 8'h00, 1'b0, 8'h00, 20'h0, 8'h00);
      final_report;
   end
endmodule
`default_nettype wire
